//--- core/fasd_pkg.sv
// Package of opcode patterns, field positions and clock counts for the flag and add/sub decoder.
// What this block does
// - 10011111 copies flags into accumulator_high_byte, 2 clocks.
// - 10011110 stores accumulator_high_byte into flags, 3 clocks.
// - 1111001 sets carry, 2 clocks.
// - 1111101 sets direction flag, 2 clocks.
// - 1111011 sets interrupt enable, 8 clocks.
// - 000000dw register to register add, 2 clocks.
// - 0000000w register into memory add, 7 clocks.
// - 0000001w memory into register add, 6 clocks.
// - 100000sw reg 000 immediate add, 2/7 clocks.
// - 000100dw register add with carry, 2 clocks.
// - 0001000w add with carry into memory, 7.
// - 0001001w add with carry into register, 6.
// - 100000sw reg 010 immediate add with carry, 2/7.
// - 1111111w reg 000 increment 2/6; 01000 short 2.
// - 001010dw register subtract, 2 clocks.
package fasd_pkg;

	// ------------------------------------------------------------
	// Opcode patterns
	// ------------------------------------------------------------
	localparam logic [7:0] OP_FLAGS_READ   = 8'h9F;
	localparam logic [7:0] OP_FLAGS_STORE  = 8'h9E;
	localparam logic [6:0] OP_CARRY_SET    = 7'h79;
	localparam logic [6:0] OP_DIR_SET      = 7'h7D;
	localparam logic [6:0] OP_INT_SET      = 7'h7B;
	localparam logic [5:0] OP_ADD_RM       = 6'h00;
	localparam logic [5:0] OP_ADC_RM       = 6'h04;
	localparam logic [5:0] OP_SUB_RM       = 6'h0A;
	localparam logic [5:0] OP_IMM_GROUP    = 6'h20;
	localparam logic [6:0] OP_INC_GROUP    = 7'h7F;
	localparam logic [4:0] OP_INC_SHORT    = 5'h08;
	localparam logic [2:0] REG_ADD         = 3'h0;
	localparam logic [2:0] REG_ADC         = 3'h2;
	localparam logic [2:0] REG_INC         = 3'h0;
	localparam logic [1:0] MOD_REGISTER    = 2'h3;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int W_BIT      = 0;
	localparam int D_BIT      = 1;
	localparam int MOD_HI     = 7;
	localparam int MOD_LO     = 6;
	localparam int REG_HI     = 5;
	localparam int REG_LO     = 3;
	localparam int CARRY_POS  = 0;
	localparam int INT_POS    = 9;
	localparam int DIR_POS    = 10;

	// ------------------------------------------------------------
	// Clock counts and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] CLK_FLAGS_READ  = 4'h2;
	localparam logic [3:0] CLK_FLAGS_STORE = 4'h3;
	localparam logic [3:0] CLK_CARRY_SET   = 4'h2;
	localparam logic [3:0] CLK_DIR_SET     = 4'h2;
	localparam logic [3:0] CLK_INT_SET     = 4'h8;
	localparam logic [3:0] CLK_REG_REG     = 4'h2;
	localparam logic [3:0] CLK_REG_TO_MEM  = 4'h7;
	localparam logic [3:0] CLK_MEM_TO_REG  = 4'h6;
	localparam logic [3:0] CLK_IMM_MEM     = 4'h7;
	localparam logic [3:0] CLK_INC_MEM     = 4'h6;
	localparam logic [3:0] CLK_ONE         = 4'h1;
	localparam logic [15:0] FLAGS_RESET    = 16'h0002;
	localparam logic [7:0]  HIGH_BYTE_RESET = 8'h00;

	typedef enum logic [4:0] {
		FASD_OP_NONE        = 5'h00,
		FASD_OP_FLAGS_READ  = 5'h01,
		FASD_OP_FLAGS_STORE = 5'h02,
		FASD_OP_CARRY_SET   = 5'h03,
		FASD_OP_DIR_SET     = 5'h04,
		FASD_OP_INT_SET     = 5'h05,
		FASD_OP_ADD         = 5'h06,
		FASD_OP_ADC         = 5'h07,
		FASD_OP_INC         = 5'h08,
		FASD_OP_SUB         = 5'h09
	} fasd_op_t;

endpackage

//--- core/fasd_countdown.sv
// Down counter that holds an instruction busy for its clock count.
`timescale 1ns/1ps
module fasd_countdown (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       load_i,
	input  wire logic [3:0] count_i,
	output logic            busy_o,
	output logic            last_o
);
	import fasd_pkg::*;

	logic [3:0] left_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left_reg <= 4'h0;
		end else if (load_i) begin
			left_reg <= count_i;
		end else if (left_reg != 4'h0) begin
			left_reg <= left_reg - CLK_ONE;
		end
	end

	// Busy lasts as many cycles after the load edge as the value loaded.
	assign busy_o = (left_reg != 4'h0);
	assign last_o = (left_reg == CLK_ONE);
endmodule // fasd_countdown

//--- core/fasd_decoder.sv
// Top of the flag-control and add/subtract decoder with its cycle timing.
`timescale 1ns/1ps
module fasd_decoder (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 issue_i,
	input  wire logic [7:0]           opcode_i,
	input  wire logic [7:0]           modrm_i,
	input  wire logic [15:0]          flags_i,
	input  wire logic [7:0]           accumulator_high_byte_i,
	output logic                      ready_o,
	output logic                      done_o,
	output logic                      illegal_o,
	output fasd_pkg::fasd_op_t        op_o,
	output logic                      wide_o,
	output logic                      reg_is_dest_o,
	output logic                      mem_operand_o,
	output logic                      use_carry_o,
	output logic                      subtract_o,
	output logic                      imm_follows_o,
	output logic                      sign_extend_o,
	output logic [2:0]                reg_index_o,
	output logic [3:0]                clocks_o,
	output logic [15:0]               flags_o,
	output logic                      flags_we_o,
	output logic [7:0]                accumulator_high_byte_o,
	output logic                      accumulator_high_byte_we_o
);
	import fasd_pkg::*;

	// ------------------------------------------------------------
	// Field helpers
	// ------------------------------------------------------------
	// Any mode other than the register mode names a memory operand.
	function automatic logic is_mem(input logic [7:0] m);
		return m[MOD_HI:MOD_LO] != MOD_REGISTER;
	endfunction

	// The middle field names a register or extends the opcode.
	function automatic logic [2:0] reg_field(input logic [7:0] m);
		return m[REG_HI:REG_LO];
	endfunction

	// Two-operand and immediate forms carry their class in the top six bits.
	function automatic logic [5:0] group_field(input logic [7:0] o);
		return o[7:2];
	endfunction

	// Flag patterns are seven bits wide and sit in the low bits, so bit 7 is not decoded.
	function automatic logic [6:0] flag_field(input logic [7:0] o);
		return o[6:0];
	endfunction

	// Register forms take the short count; otherwise the direction bit picks the memory count.
	function automatic logic [3:0] alu_clocks(input logic mem, input logic d);
		return !mem ? CLK_REG_REG : (d ? CLK_MEM_TO_REG : CLK_REG_TO_MEM);
	endfunction

	// Decoded values before they are captured.
	fasd_op_t   op_next;
	logic [3:0] clk_next;
	logic       wide_next;
	logic       dest_next;
	logic       mem_next;
	logic       imm_next;
	logic       sext_next;
	logic       hit_next;
	logic [2:0] reg_next;
	// Form matches.
	logic       is_read_flags;
	logic       is_store_flags;
	logic       is_carry_set;
	logic       is_dir_set;
	logic       is_int_set;
	logic       is_alu;
	logic       is_imm;
	logic       is_inc_group;
	logic       is_inc_short;
	logic       is_sub_mem;
	logic       mem_form;
	// Count handling.
	logic [3:0] load_count;
	logic       busy;
	logic       last;
	logic       take;

	// ------------------------------------------------------------
	// Form match
	// ------------------------------------------------------------
	// Each form is matched apart, which keeps the priority chain below short.
	always_comb begin
		is_read_flags  = (opcode_i == OP_FLAGS_READ);
		is_store_flags = (opcode_i == OP_FLAGS_STORE);
		is_carry_set   = (flag_field(opcode_i) == OP_CARRY_SET);
		is_dir_set     = (flag_field(opcode_i) == OP_DIR_SET);
		is_int_set     = (flag_field(opcode_i) == OP_INT_SET);
		is_alu         = (group_field(opcode_i) == OP_ADD_RM)
			|| (group_field(opcode_i) == OP_ADC_RM)
			|| (group_field(opcode_i) == OP_SUB_RM);
		// Only add and add with carry of the immediate group belong here.
		is_imm         = (group_field(opcode_i) == OP_IMM_GROUP)
			&& (reg_field(modrm_i) == REG_ADD || reg_field(modrm_i) == REG_ADC);
		is_inc_group   = (opcode_i[7:1] == OP_INC_GROUP) && (reg_field(modrm_i) == REG_INC);
		is_inc_short   = (opcode_i[7:3] == OP_INC_SHORT);
		mem_form       = is_mem(modrm_i);
		// The memory forms of subtract lie outside this decoder.
		is_sub_mem     = (group_field(opcode_i) == OP_SUB_RM) && mem_form;
	end

	// ------------------------------------------------------------
	// Operation and count
	// ------------------------------------------------------------
	// Opcodes that match no form raise illegal and leave every output alone.
	always_comb begin
		op_next  = FASD_OP_NONE;
		clk_next = CLK_ONE;
		hit_next = 1'b1;
		if (is_read_flags) begin
			op_next  = FASD_OP_FLAGS_READ;
			clk_next = CLK_FLAGS_READ;
		end else if (is_store_flags) begin
			op_next  = FASD_OP_FLAGS_STORE;
			clk_next = CLK_FLAGS_STORE;
		end else if (is_carry_set) begin
			op_next  = FASD_OP_CARRY_SET;
			clk_next = CLK_CARRY_SET;
		end else if (is_dir_set) begin
			op_next  = FASD_OP_DIR_SET;
			clk_next = CLK_DIR_SET;
		end else if (is_int_set) begin
			op_next  = FASD_OP_INT_SET;
			clk_next = CLK_INT_SET;
		end else if (is_alu) begin
			if (group_field(opcode_i) == OP_ADD_RM) begin
				op_next = FASD_OP_ADD;
			end else if (group_field(opcode_i) == OP_ADC_RM) begin
				op_next = FASD_OP_ADC;
			end else begin
				op_next = FASD_OP_SUB;
			end
			clk_next = alu_clocks(mem_form, opcode_i[D_BIT]);
			hit_next = !is_sub_mem;
		end else if (is_imm) begin
			op_next  = (reg_field(modrm_i) == REG_ADD) ? FASD_OP_ADD : FASD_OP_ADC;
			clk_next = mem_form ? CLK_IMM_MEM : CLK_REG_REG;
		end else if (is_inc_group || is_inc_short) begin
			op_next  = FASD_OP_INC;
			clk_next = (is_inc_group && mem_form) ? CLK_INC_MEM : CLK_REG_REG;
		end else begin
			hit_next = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Operand fields
	// ------------------------------------------------------------
	// Immediate and increment group forms use the middle field as opcode, so no register is named.
	always_comb begin
		wide_next = opcode_i[W_BIT];
		dest_next = opcode_i[D_BIT];
		mem_next  = 1'b0;
		imm_next  = 1'b0;
		sext_next = 1'b0;
		reg_next  = reg_field(modrm_i);
		if (is_alu) begin
			mem_next = mem_form;
		end else if (is_imm) begin
			mem_next  = mem_form;
			imm_next  = 1'b1;
			sext_next = opcode_i[D_BIT];
			dest_next = 1'b0;
			reg_next  = 3'h0;
		end else if (is_inc_group) begin
			mem_next  = mem_form;
			dest_next = 1'b0;
			reg_next  = 3'h0;
		end else if (is_inc_short) begin
			// The short increment names its register in the opcode and works at full size.
			wide_next = 1'b1;
			dest_next = 1'b1;
			reg_next  = opcode_i[2:0];
		end
	end

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	// A new opcode is only accepted once the previous one has used up its count.
	assign take = issue_i && ready_o && hit_next;

	// Loading one less than the count lets done and ready rise in the count's last cycle.
	assign load_count = clk_next - CLK_ONE;

	fasd_countdown fasd_countdown_i (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.load_i  (take),
		.count_i (load_count),
		.busy_o  (busy),
		.last_o  (last)
	);

	// Ready returns together with done, so a new opcode may issue in the done cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_o <= 1'b1;
			done_o  <= 1'b0;
		end else begin
			ready_o <= !(take || (busy && !last));
			done_o  <= last && !take;
		end
	end

	// An unrecognised opcode only pulses illegal; no other state or output changes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			illegal_o <= 1'b0;
		end else begin
			illegal_o <= issue_i && ready_o && !hit_next;
		end
	end

	// ------------------------------------------------------------
	// Decoded fields
	// ------------------------------------------------------------
	// Fields are captured only on a take, so they stand until the next accepted opcode.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_o          <= FASD_OP_NONE;
			wide_o        <= 1'b0;
			reg_is_dest_o <= 1'b0;
			mem_operand_o <= 1'b0;
			use_carry_o   <= 1'b0;
			subtract_o    <= 1'b0;
			imm_follows_o <= 1'b0;
			sign_extend_o <= 1'b0;
			reg_index_o   <= 3'h0;
			clocks_o      <= 4'h0;
		end else if (take) begin
			op_o          <= op_next;
			wide_o        <= wide_next;
			reg_is_dest_o <= dest_next;
			mem_operand_o <= mem_next;
			use_carry_o   <= (op_next == FASD_OP_ADC);
			subtract_o    <= (op_next == FASD_OP_SUB);
			imm_follows_o <= imm_next;
			sign_extend_o <= sext_next;
			reg_index_o   <= reg_next;
			clocks_o      <= clk_next;
		end
	end

	// ------------------------------------------------------------
	// Flag and accumulator high byte effects
	// ------------------------------------------------------------
	// Writes land on the issue edge; the core must not read flags again until done.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_o    <= FLAGS_RESET;
			flags_we_o <= 1'b0;
		end else begin
			flags_we_o <= 1'b0;
			if (take) begin
				unique case (op_next)
					FASD_OP_FLAGS_STORE: begin
						flags_o    <= {flags_i[15:8], accumulator_high_byte_i};
						flags_we_o <= 1'b1;
					end
					FASD_OP_CARRY_SET: begin
						flags_o            <= flags_i;
						flags_o[CARRY_POS] <= 1'b1;
						flags_we_o         <= 1'b1;
					end
					FASD_OP_DIR_SET: begin
						flags_o          <= flags_i;
						flags_o[DIR_POS] <= 1'b1;
						flags_we_o       <= 1'b1;
					end
					FASD_OP_INT_SET: begin
						flags_o          <= flags_i;
						flags_o[INT_POS] <= 1'b1;
						flags_we_o       <= 1'b1;
					end
					default: begin
						flags_o <= flags_o;
					end
				endcase
			end
		end
	end

	// A flags read returns the low byte of the flags word sampled at issue.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			accumulator_high_byte_o    <= HIGH_BYTE_RESET;
			accumulator_high_byte_we_o <= 1'b0;
		end else begin
			accumulator_high_byte_we_o <= take && (op_next == FASD_OP_FLAGS_READ);
			if (take && op_next == FASD_OP_FLAGS_READ) begin
				accumulator_high_byte_o <= flags_i[7:0];
			end
		end
	end
endmodule // fasd_decoder

//--- verification/fasd_decoder_asserts.sv
// Checker of decode timing and decode relations.
`timescale 1ns/1ps
module fasd_asserts
	import fasd_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        issue_i,
	input wire logic [7:0]  opcode_i,
	input wire logic [7:0]  modrm_i,
	input wire logic [15:0] flags_i,
	input wire logic        ready_o,
	input wire logic        done_o,
	input wire logic        illegal_o,
	input fasd_op_t         op_o,
	input wire logic        wide_o,
	input wire logic        reg_is_dest_o,
	input wire logic        subtract_o,
	input wire logic [3:0]  clocks_o,
	input wire logic [15:0] flags_o,
	input wire logic        flags_we_o
);
	// ----
	// Busy length counter
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] low_reg;
	wire take = issue_i && ready_o;
	always_ff @(posedge clk_i) begin
		if (rst_i || ready_o) begin
			low_reg <= 4'h0;
		end else begin
			low_reg <= low_reg + 4'h1;
		end
	end
	a_done_count: assert property (
		done_o |-> ready_o && low_reg == clocks_o - 4'h1) else $error("done after wrong count");
	a_carry_two: assert property (
		take && opcode_i == 8'hF9 |=> !ready_o && op_o == FASD_OP_CARRY_SET && flags_we_o
		&& flags_o == ($past(flags_i) | 16'h0001) ##1 done_o) else $error("carry set bad");
	a_int_eight: assert property (
		take && opcode_i == 8'hFB |=> (flags_o[9] && !done_o) ##1 (!done_o)[*6] ##1 done_o)
		else $error("interrupt set bad");
	a_store_three: assert property (
		take && opcode_i == 8'h9E |=> flags_we_o && op_o == FASD_OP_FLAGS_STORE ##1 !done_o
		##1 done_o) else $error("flag store bad");
	a_dir_set: assert property (
		take && opcode_i == 8'hFD |=> flags_o[10] && op_o == FASD_OP_DIR_SET)
		else $error("direction set bad");
	a_add_fields: assert property (
		take && opcode_i[7:2] == 6'h00 && modrm_i[7:6] == 2'b11 |=> op_o == FASD_OP_ADD
		&& wide_o == $past(opcode_i[0]) && reg_is_dest_o == $past(opcode_i[1])
		&& clocks_o == 4'h2) else $error("add fields bad");
	a_sub_reg: assert property (
		take && opcode_i[7:2] == 6'h0A && modrm_i[7:6] == 2'b11 |=> subtract_o
		&& op_o == FASD_OP_SUB ##1 done_o) else $error("subtract bad");
	a_illegal_idle: assert property (
		illegal_o |-> ready_o && !flags_we_o && $past(issue_i)) else $error("illegal bad");
	c_int: cover property (take && opcode_i == 8'hFB);
	c_illegal: cover property (illegal_o);
	c_b2b: cover property (done_o && issue_i);
endmodule // fasd_asserts

bind fasd_decoder fasd_asserts fasd_asserts_i (.clk_i, .rst_i, .issue_i, .opcode_i,
	.modrm_i, .flags_i, .ready_o, .done_o, .illegal_o, .op_o, .wide_o, .reg_is_dest_o,
	.subtract_o, .clocks_o, .flags_o, .flags_we_o);

//--- verification/tb_fasd_decoder.sv
// Self-checking bench for the flag and add/subtract decoder.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module tb_fasd_decoder;
	import fasd_pkg::*;
	logic clk_i, rst_i, issue_i, ready_o, done_o, illegal_o, wide_o, reg_is_dest_o;
	logic mem_operand_o, use_carry_o, subtract_o, imm_follows_o, sign_extend_o;
	logic flags_we_o, accumulator_high_byte_we_o;
	logic [7:0] opcode_i, modrm_i, accumulator_high_byte_i, accumulator_high_byte_o;
	logic [15:0] flags_i, flags_o, snap_f;
	logic [7:0] snap_a;
	logic [2:0] reg_index_o;
	logic [3:0] clocks_o;
	fasd_op_t op_o;
	int miscompares = 0;
	int check_count = 0;
	fasd_decoder fasd_decoder_i (.clk_i, .rst_i, .issue_i, .opcode_i, .modrm_i, .flags_i,
		.accumulator_high_byte_i, .ready_o, .done_o, .illegal_o, .op_o, .wide_o,
		.reg_is_dest_o, .mem_operand_o, .use_carry_o, .subtract_o, .imm_follows_o,
		.sign_extend_o, .reg_index_o, .clocks_o, .flags_o, .flags_we_o,
		.accumulator_high_byte_o, .accumulator_high_byte_we_o);
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----
	// One instruction, issued at a falling edge; fields are checked only where chk is set.
	// ----
	task automatic run_op(input logic [7:0] opc, input logic [7:0] mrm, input fasd_op_t eop,
		input logic [3:0] ecl, input logic chk, input logic [6:0] ef, input logic [2:0] ri);
		int n;
		issue_i = 1'b1;
		opcode_i = opc;
		modrm_i = mrm;
		@(negedge clk_i);
		issue_i = 1'b0;
		snap_f = flags_we_o ? flags_o : 16'hxxxx;
		snap_a = accumulator_high_byte_we_o ? accumulator_high_byte_o : 8'hxx;
		`CHK("op", eop, op_o)
		`CHK("count", ecl, clocks_o)
		`CHK("busy", 1'b0, ready_o)
		if (chk) begin
			`CHK("fields", ef, {wide_o, reg_is_dest_o, mem_operand_o, use_carry_o,
				subtract_o, imm_follows_o, sign_extend_o})
			`CHK("reg", ri, reg_index_o)
		end
		n = 1;
		while (done_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		`CHK("clocks", ecl, n[3:0])
		`CHK("ready", 1'b1, ready_o)
	endtask
	task automatic t_reset();
		`CHK("ready", 1'b1, ready_o)
		`CHK("op", FASD_OP_NONE, op_o)
		`CHK("flags", 16'h0002, flags_o)
	endtask
	task automatic t_flags();
		flags_i = 16'h00C4;
		accumulator_high_byte_i = 8'hA7;
		run_op(8'h9F, 8'h00, FASD_OP_FLAGS_READ, 4'h2, 1'b0, 7'h00, 3'h0);
		`CHK("ah", 8'hC4, snap_a)
		run_op(8'h9E, 8'h00, FASD_OP_FLAGS_STORE, 4'h3, 1'b0, 7'h00, 3'h0);
		`CHK("flags", 16'h00A7, snap_f)
		run_op(8'hF9, 8'h00, FASD_OP_CARRY_SET, 4'h2, 1'b0, 7'h00, 3'h0);
		`CHK("flags", 16'h00C5, snap_f)
		run_op(8'hFD, 8'h00, FASD_OP_DIR_SET, 4'h2, 1'b0, 7'h00, 3'h0);
		`CHK("flags", 16'h04C4, snap_f)
		run_op(8'hFB, 8'h00, FASD_OP_INT_SET, 4'h8, 1'b0, 7'h00, 3'h0);
		`CHK("flags", 16'h02C4, snap_f)
	endtask
	task automatic t_add();
		run_op(8'h03, 8'hC8, FASD_OP_ADD, 4'h2, 1'b1, 7'b1100000, 3'h1);
		run_op(8'h00, 8'h0A, FASD_OP_ADD, 4'h7, 1'b1, 7'b0010000, 3'h1);
		run_op(8'h02, 8'h13, FASD_OP_ADD, 4'h6, 1'b1, 7'b0110000, 3'h2);
		run_op(8'h83, 8'hC0, FASD_OP_ADD, 4'h2, 1'b1, 7'b1000011, 3'h0);
		run_op(8'h80, 8'h06, FASD_OP_ADD, 4'h7, 1'b1, 7'b0010010, 3'h0);
	endtask
	task automatic t_adc();
		run_op(8'h11, 8'hC8, FASD_OP_ADC, 4'h2, 1'b1, 7'b1001000, 3'h1);
		run_op(8'h10, 8'h18, FASD_OP_ADC, 4'h7, 1'b1, 7'b0011000, 3'h3);
		run_op(8'h13, 8'h20, FASD_OP_ADC, 4'h6, 1'b1, 7'b1111000, 3'h4);
		run_op(8'h81, 8'hD0, FASD_OP_ADC, 4'h2, 1'b1, 7'b1001010, 3'h0);
		run_op(8'h82, 8'h16, FASD_OP_ADC, 4'h7, 1'b1, 7'b0011011, 3'h0);
	endtask
	task automatic t_inc_sub();
		run_op(8'hFF, 8'hC0, FASD_OP_INC, 4'h2, 1'b0, 7'h00, 3'h0);
		run_op(8'hFE, 8'h06, FASD_OP_INC, 4'h6, 1'b0, 7'h00, 3'h0);
		run_op(8'h47, 8'h00, FASD_OP_INC, 4'h2, 1'b1, 7'b1100000, 3'h7);
		run_op(8'h2B, 8'hD8, FASD_OP_SUB, 4'h2, 1'b1, 7'b1100100, 3'h3);
		run_op(8'h28, 8'hC1, FASD_OP_SUB, 4'h2, 1'b1, 7'b0000100, 3'h0);
	endtask
	// A memory subtract is refused, and an issue while busy is ignored.
	task automatic t_refuse();
		issue_i = 1'b1;
		opcode_i = 8'h2A;
		modrm_i = 8'h06;
		@(negedge clk_i);
		`CHK("illegal", 1'b1, illegal_o)
		`CHK("ready", 1'b1, ready_o)
		opcode_i = 8'hFB;
		@(negedge clk_i);
		opcode_i = 8'hF9;
		@(negedge clk_i);
		issue_i = 1'b0;
		repeat (6) @(negedge clk_i);
		`CHK("done", 1'b1, done_o)
		`CHK("op", FASD_OP_INT_SET, op_o)
	endtask
	initial begin
		rst_i = 1'b1;
		issue_i = 1'b0;
		opcode_i = 8'h00;
		modrm_i = 8'h00;
		flags_i = 16'h0000;
		accumulator_high_byte_i = 8'h00;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		t_reset();
		t_flags();
		t_add();
		t_adc();
		t_inc_sub();
		t_refuse();
		finish_test();
	end
	initial begin
		#200000;
		miscompares++;
		finish_test();
	end
endmodule // tb_fasd_decoder
